// [hdl/iusch_top.sv]
// Isochronous microframe scheduler with Wishbone register access
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "iusch_regs.svh"

module iusch_top (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  sof_pulse,
  input  wire iusch_pkg::iusch_frame_t  bus_frame,
  input  wire iusch_pkg::iusch_uframe_t bus_uframe,
  output logic                       xfer_req,
  output iusch_pkg::iusch_uframe_t   xfer_uframe,
  output logic                       xfer_dir_in,
  input  wire logic                  xfer_done,
  input  wire iusch_pkg::iusch_count_t  xfer_rx_count,
  input  wire logic                  xfer_txn_err,
  input  wire logic                  xfer_babble,
  input  wire logic                  xfer_underrun
);
  import iusch_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Descriptor state written by software and by the scheduler

  logic [7:0]      frame_byte_ff;
  logic [1:0]      token_ff;
  logic [7:0]      mask_ff;
  logic [7:0]      nxt_mask;
  iusch_state_t    state_ff;
  iusch_state_t    nxt_state;
  iusch_uframe_t   cur_uf_ff;
  logic            dir_in_ff;
  logic            ack_ff;
  logic [31:0]     rd_data_ff;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone decode

  logic            bus_req;
  logic            wr_now;
  logic            hit_ctrl;
  logic            hit_mask;
  logic            hit_result;
  logic            hit_stat;
  logic            hit_count;
  logic [2:0]      count_idx;
  logic [7:0]      count_off;
  logic [31:0]     rd_mux;

  assign bus_req    = wb_cyc_i & wb_stb_i;
  // Writes land on the edge at which the master samples ack
  assign wr_now     = bus_req & wb_we_i & ack_ff;
  assign hit_ctrl   = (wb_adr_i == `IUSCH_OFF_CTRL);
  assign hit_mask   = (wb_adr_i == `IUSCH_OFF_MASK);
  assign hit_result = (wb_adr_i == `IUSCH_OFF_RESULT);
  assign hit_stat   = (wb_adr_i == `IUSCH_OFF_STAT);
  assign hit_count  = (wb_adr_i >= `IUSCH_OFF_COUNT0) &&
                      (wb_adr_i <= `IUSCH_OFF_COUNT7) &&
                      (wb_adr_i[1:0] == 2'h0);
  assign count_off  = wb_adr_i - `IUSCH_OFF_COUNT0;
  assign count_idx  = count_off[4:2];

  iusch_store_if   st_if ();

  // Unmapped addresses still ack, reading as zero
  assign rd_mux =
    hit_ctrl   ? {22'h0, token_ff, frame_byte_ff} :
    hit_mask   ? {24'h0, mask_ff} :
    hit_result ? {8'h0, st_if.results} :
    hit_stat   ? {16'h0, 7'h0, (state_ff == ST_BUSY), bus_frame,
                  bus_uframe} :
    hit_count  ? {20'h0, st_if.counts[count_idx]} :
                 32'h0;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff     <= 1'b0;
      rd_data_ff <= 32'h0;
    end else begin
      ack_ff     <= bus_req & ~ack_ff;
      rd_data_ff <= (bus_req & ~ack_ff) ? rd_mux : rd_data_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_data_ff;

  ////////////////////////////////////////////////////////////////////////
  // Frame byte and token

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_byte_ff <= `IUSCH_RST_FRAME;
      token_ff      <= `IUSCH_RST_TOKEN;
    end else if (wr_now && hit_ctrl) begin
      if (wb_sel_i[0])
        frame_byte_ff <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        token_ff <= wb_dat_i[`IUSCH_TOKEN_HI:`IUSCH_TOKEN_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame match and microframe selection

  logic            frame_match;
  logic            uf_active;
  logic            token_in;
  logic            start_xfer;
  logic            finish_ok;

  // Low three bits of the frame byte never take part in the compare
  assign frame_match = (frame_byte_ff[`IUSCH_FRAME_HI:`IUSCH_FRAME_LO] ==
                        bus_frame);
  assign uf_active   = mask_ff[bus_uframe];
  assign token_in    = (token_ff == `IUSCH_TOKEN_IN);
  assign start_xfer  = (state_ff == ST_IDLE) & sof_pulse &
                       frame_match & uf_active;
  // A finish outside the matching frame or on a cleared bit ends the request but clears no mask bit and writes nothing back
  assign finish_ok   = (state_ff == ST_BUSY) & xfer_done &
                       frame_match & mask_ff[cur_uf_ff];

  ////////////////////////////////////////////////////////////////////////
  // Scheduler state

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_xfer)
          nxt_state = ST_BUSY;
      end
      ST_BUSY: begin
        if (xfer_done)
          nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff  <= ST_IDLE;
      cur_uf_ff <= 3'h0;
      dir_in_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start_xfer) begin
        cur_uf_ff <= bus_uframe;
        dir_in_ff <= token_in;
      end
    end
  end

  assign xfer_req    = (state_ff == ST_BUSY);
  assign xfer_uframe = cur_uf_ff;
  assign xfer_dir_in = dir_in_ff;

  ////////////////////////////////////////////////////////////////////////
  // Active mask: software sets, hardware clears after processing

  logic [7:0]      sw_set;
  logic [7:0]      hw_clr;

  assign sw_set = (wr_now && hit_mask && wb_sel_i[0]) ? wb_dat_i[7:0]
                                                      : 8'h00;
  assign hw_clr = finish_ok ? (8'h01 << cur_uf_ff) : 8'h00;

  // A software set in the clearing cycle wins, so a new request survives
  assign nxt_mask = (mask_ff & ~hw_clr) | sw_set;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      mask_ff <= `IUSCH_RST_MASK;
    else
      mask_ff <= nxt_mask;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-back of count and result after the transaction

  logic [2:0]      res_code;

  assign res_code[`IUSCH_RES_TXN_ERR]  = xfer_txn_err;
  assign res_code[`IUSCH_RES_BABBLE]   = xfer_babble & dir_in_ff;
  assign res_code[`IUSCH_RES_UNDERRUN] = xfer_underrun & ~dir_in_ff;

  // Fields move only on the finish of the transaction itself
  assign st_if.upd_sel    = hw_clr;
  assign st_if.upd_count  = xfer_rx_count;
  assign st_if.upd_result = res_code;

  iusch_store #(
    .NUM_UF (`IUSCH_UFRAMES)
  ) u_store (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .st      (st_if.store)
  );

endmodule : iusch_top
`default_nettype wire

// [hdl/iusch_regs.svh]
// Register offsets, field positions and reset values of the scheduler
`ifndef IUSCH_REGS_SVH
`define IUSCH_REGS_SVH

`define IUSCH_UFRAMES        8
`define IUSCH_CNT_W          12
`define IUSCH_RES_W          3

`define IUSCH_OFF_CTRL       8'h00
`define IUSCH_OFF_MASK       8'h04
`define IUSCH_OFF_RESULT     8'h08
`define IUSCH_OFF_STAT       8'h0c
`define IUSCH_OFF_COUNT0     8'h10
`define IUSCH_OFF_COUNT7     8'h2c

`define IUSCH_FRAME_HI       7
`define IUSCH_FRAME_LO       3
`define IUSCH_TOKEN_LO       8
`define IUSCH_TOKEN_HI       9

`define IUSCH_TOKEN_OUT      2'h0
`define IUSCH_TOKEN_IN       2'h1

`define IUSCH_RES_TXN_ERR    0
`define IUSCH_RES_BABBLE     1
`define IUSCH_RES_UNDERRUN   2

`define IUSCH_RST_FRAME      8'h00
`define IUSCH_RST_TOKEN      2'h0
`define IUSCH_RST_MASK       8'h00

`endif

// [hdl/iusch_pkg.sv]
// Types shared by the isochronous microframe scheduler
package iusch_pkg;
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_BUSY
  } iusch_state_t;
  typedef logic [11:0] iusch_count_t;
  typedef logic [2:0]  iusch_result_t;
  typedef logic [2:0]  iusch_uframe_t;
  typedef logic [4:0]  iusch_frame_t;
endpackage : iusch_pkg

// [hdl/iusch_store_if.sv]
// Carrier between the scheduler and its per-microframe result store
`timescale 1ns/1ps
`default_nettype none
interface iusch_store_if;
  logic [7:0]        upd_sel;
  logic [11:0]       upd_count;
  logic [2:0]        upd_result;
  logic [7:0][11:0]  counts;
  logic [7:0][2:0]   results;
  modport ctrl (output upd_sel, output upd_count, output upd_result,
                input counts, input results);
  modport store (input upd_sel, input upd_count, input upd_result,
                 output counts, output results);
endinterface : iusch_store_if
`default_nettype wire

// [hdl/iusch_store.sv]
// Per-microframe received-byte counts and result codes
`timescale 1ns/1ps
`default_nettype none
module iusch_store #(
  parameter int NUM_UF = 8
) (
  input  wire logic           ref_clk,
  input  wire logic           sys_rst,
  iusch_store_if.store        st
);
  import iusch_pkg::*;

  logic [NUM_UF-1:0][11:0] count_ff;
  logic [NUM_UF-1:0][2:0]  result_ff;

  ////////////////////////////////////////////////////////////////////////
  // Only the selected slot moves; the others keep their last outcome
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff  <= '0;
      result_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_UF; i++) begin
        if (st.upd_sel[i]) begin
          count_ff[i]  <= st.upd_count;
          result_ff[i] <= st.upd_result;
        end
      end
    end
  end

  assign st.counts  = count_ff;
  assign st.results = result_ff;
endmodule : iusch_store
`default_nettype wire

// [verif/iusch_monitor.sv]
// Assertion checker for the isochronous microframe scheduler
`timescale 1ns/1ps
`default_nettype none
module iusch_monitor (
  input wire logic                     ref_clk,
  input wire logic                     sys_rst,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [7:0]               wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic                     wb_ack_o,
  input wire logic                     sof_pulse,
  input wire iusch_pkg::iusch_frame_t  bus_frame,
  input wire iusch_pkg::iusch_uframe_t bus_uframe,
  input wire logic                     xfer_req,
  input wire iusch_pkg::iusch_uframe_t xfer_uframe,
  input wire logic                     xfer_dir_in,
  input wire logic                     xfer_done
);
  import iusch_pkg::*;
  logic [4:0] frm_ff;
  logic       tok_ff;
  logic       wr_ctrl;
  // Shadow of the frame and token, so starts can be tied to software setup
  assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                   && wb_adr_i == 8'h00;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frm_ff <= 5'h00;
      tok_ff <= 1'b0;
    end else if (wr_ctrl) begin
      if (wb_sel_i[0]) frm_ff <= wb_dat_i[7:3];
      if (wb_sel_i[1]) tok_ff <= wb_dat_i[9:8] == 2'h1;
    end
  end
  //////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  req_sof_a: assert property ($rose(xfer_req) |-> $past(sof_pulse))
    else $error("transfer started without microframe start");
  req_uframe_a: assert property ($rose(xfer_req) |->
    xfer_uframe == $past(bus_uframe)) else $error("wrong microframe");
  req_frame_a: assert property ($rose(xfer_req) |->
    $past(bus_frame) == $past(frm_ff)) else $error("frame mismatch start");
  req_dir_a: assert property ($rose(xfer_req) |->
    xfer_dir_in == $past(tok_ff)) else $error("wrong direction");
  req_hold_a: assert property (xfer_req && !xfer_done |=>
    xfer_req && $stable(xfer_uframe)) else $error("request dropped early");
  req_end_a: assert property (xfer_req && xfer_done |=> !xfer_req)
    else $error("request not ended after done");
  req_fall_a: assert property ($fell(xfer_req) |-> $past(xfer_done))
    else $error("request fell without done");
  cover property ($rose(xfer_req) && xfer_dir_in);
  cover property ($rose(xfer_req) && !xfer_dir_in);
  cover property (wr_ctrl);
endmodule : iusch_monitor
bind iusch_top iusch_monitor iusch_monitor_i (.*);
`default_nettype wire

// [verif/iusch_link_model.sv]
// Behavioural isochronous endpoint answering transfer requests
`timescale 1ns/1ps
`default_nettype none
module iusch_link_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        xfer_req,
  input  wire logic [3:0]  lk_delay,
  input  wire logic [11:0] lk_cnt,
  input  wire logic [2:0]  lk_flg,
  output logic             xfer_done,
  output logic [11:0]      xfer_rx_count,
  output logic [2:0]       xfer_flags
);
  logic [3:0] wait_ff;
  logic       spent_ff;
  // Data lines toggle outside done so stale values are never trusted
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff       <= 4'h0;
      spent_ff      <= 1'b0;
      xfer_done     <= 1'b0;
      xfer_rx_count <= 12'h000;
      xfer_flags    <= 3'h0;
    end else begin
      xfer_done     <= 1'b0;
      xfer_rx_count <= ~xfer_rx_count;
      xfer_flags    <= ~xfer_flags;
      if (!xfer_req) begin
        wait_ff  <= 4'h0;
        spent_ff <= 1'b0;
      end else if (!spent_ff && wait_ff == lk_delay) begin
        xfer_done     <= 1'b1;
        xfer_rx_count <= lk_cnt;
        xfer_flags    <= lk_flg;
        spent_ff      <= 1'b1;
      end else if (!spent_ff) begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : iusch_link_model
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the isochronous microframe scheduler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import iusch_pkg::*;
  logic          ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic          sof_pulse, xfer_req, xfer_dir_in, xfer_done;
  logic [7:0]    wb_adr_i;
  logic [3:0]    wb_sel_i, lk_delay;
  logic [31:0]   wb_dat_i, wb_dat_o, rd;
  logic [11:0]   lk_cnt;
  logic [2:0]    lk_flg, xfer_flags;
  logic          xfer_txn_err, xfer_babble, xfer_underrun;
  iusch_frame_t  bus_frame;
  iusch_uframe_t bus_uframe, xfer_uframe;
  iusch_count_t  xfer_rx_count;
  int            fails, checks_done, cyc_n, seed, mask_m, ctrl_m, tok_m;
  int            frm_m, cnt_m[8], res_m[8];
  assign xfer_txn_err  = xfer_flags[0];
  assign xfer_babble   = xfer_flags[1];
  assign xfer_underrun = xfer_flags[2];
  iusch_top        iusch_top_i (.*);
  iusch_link_model iusch_link_model_i (.*);
  //////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    // Only the bench timeout ends a wait for ack
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'h3, we, a, 4'hf, d};
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  function automatic int res_word();
    int w;
    w = 0;
    for (int n = 0; n < 8; n++) w |= res_m[n] << (3 * n);
    return w;
  endfunction : res_word
  task automatic check_all;
    wb(1'b0, 8'h04, 32'h0, rd);
    `CHK("mask", mask_m, rd)
    wb(1'b0, 8'h08, 32'h0, rd);
    `CHK("result", res_word(), rd)
    for (int n = 0; n < 8; n++) begin
      wb(1'b0, 8'h10 + 8'(4 * n), 32'h0, rd);
      `CHK("count", cnt_m[n], rd)
    end
    wb(1'b0, 8'h00, 32'h0, rd);
    `CHK("ctrl", ctrl_m & 32'h3f8, rd & 32'h3f8)
    // Live status: idle here, so the busy bit must read zero
    wb(1'b0, 8'h0c, 32'h0, rd);
    `CHK("stat", 32'({bus_frame, bus_uframe}), rd)
    wb(1'b0, 8'h40, 32'h0, rd);
    `CHK("unmapped", 0, rd)
  endtask : check_all
  task automatic set_ctrl(input int f, input int lo, input int tok);
    ctrl_m = (tok << 8) | (f << 3) | lo;
    frm_m = f;
    tok_m = (tok == 1);
    wb(1'b1, 8'h00, 32'(ctrl_m), rd);
  endtask : set_ctrl
  task automatic set_mask(input int m);
    mask_m |= m;
    wb(1'b1, 8'h04, 32'(m), rd);
  endtask : set_mask
  task automatic run_uf(input int f, input int u);
    int act, k;
    logic [31:0] r;
    act = (f == frm_m) && mask_m[u];
    r = $random(seed);
    @(posedge ref_clk);
    {bus_frame, bus_uframe, sof_pulse} <= {f[4:0], u[2:0], 1'b1};
    {lk_delay, lk_cnt, lk_flg} <= r[18:0];
    @(posedge ref_clk);
    sof_pulse <= 1'b0;
    #1;
    `CHK("xfer_req", act, xfer_req)
    if (act) begin
      `CHK("xfer_uframe", u, xfer_uframe)
      `CHK("xfer_dir_in", tok_m, xfer_dir_in)
      if (r[18]) begin
        wb(1'b0, 8'h08, 32'h0, rd);
        `CHK("result_early", res_word(), rd)
      end
      cnt_m[u] = r[14:3];
      res_m[u] = tok_m ? {r[1], r[0]} : {r[2], 1'b0, r[0]};
      mask_m &= ~(1 << u);
    end
    k = 0;
    while (xfer_req === 1'b1 && k < 60) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    `CHK("xfer_end", 1'b0, xfer_req)
    check_all;
  endtask : run_uf
  initial begin
    {seed, fails, checks_done, cyc_n} = {32'd65698, 96'h0};
    {mask_m, ctrl_m, tok_m, frm_m} = 128'h0;
    cnt_m = '{default: 0};
    res_m = '{default: 0};
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, sof_pulse} = 5'h10;
    {wb_adr_i, wb_sel_i, wb_dat_i, bus_frame, bus_uframe} = 52'h0f0000000000;
    {lk_delay, lk_cnt, lk_flg} = 19'h0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    check_all;
    wb(1'b1, 8'h08, 32'hffffff, rd);
    wb(1'b1, 8'h40, 32'hffffffff, rd);
    set_ctrl(9, 7, 1);
    set_mask(8'hff);
    for (int u = 0; u < 8; u++) run_uf(9, u);
    set_ctrl(20, 2, 0);
    set_mask(8'h55);
    run_uf(3, 0);
    for (int u = 0; u < 8; u++) run_uf(20, u);
    set_mask(8'h80);
    set_mask(8'h02);
    run_uf(20, 7);
    run_uf(20, 1);
    run_uf(20, 1);
    test_done;
  end
endmodule : testbench
`default_nettype wire
